// ===== logic/pfwp_top.v
// Summary of operation
// - code-protect refuses external reads and writes; internal accesses unaffected
// - write-protect at zero blocks all internal writes and erases
// - active segment protection blocks internal writes and erases inside its range
// - segment protection only adds; global bits still block outside it
// - segment protection active only when its disable bit is zero
// - seven-bit page field picks a 512-word page, itself protected
// - side bit zero: segment runs from zero through selected page end
// - side bit one: segment runs from page start to memory end
// - config-page bit zero also protects the last page
// - config-page bit one with side zero leaves last page open unless it is the selected page
// - each config value has a complement shadow compared continuously
// - any shadow mismatch flags parity error and forces device reset
// - config source words covered by code-protect and segment settings
`timescale 1ns/10ps
`include "pfwp_map.vh"
module pfwp_top #(
  parameter AW = 24,
  parameter PAGE_BITS = 7,
  parameter LAST_PAGE = 7'h7F
) (
  input wire CLOCK,
  input wire RST,
  input wire CE,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output wire HREADYOUT,
  output wire HRESP,
  output reg [31:0] HRDATA,
  input wire NVM_REQ,
  input wire [AW-1:0] NVM_ADDR,
  input wire NVM_WR,
  input wire NVM_EXT,
  output reg NVM_DONE,
  output reg NVM_ALLOW,
  output reg PARITY_ERR,
  output reg DEV_RESET
);
  wire [`PFWP_CFG_W-1:0] cfg;
  wire mismatch;
  reg [7:0] a_addr_ff;
  reg a_wr_ff;
  reg a_valid_ff;
  reg [AW-1:0] sw_addr_ff;
  reg sw_wr_ff;
  reg sw_ext_ff;
  reg sw_go_ff;
  reg allow_ff;
  reg deny_ff;
  reg inseg_ff;
  reg [3:0] rstp_ff;
  reg [3:0] nxt_rstp;
  wire bus_wr;
  wire ld;
  wire poke;
  wire poke_sh;
  wire req_go;
  wire [AW-1:0] req_addr;
  wire req_wr;
  wire req_ext;
  wire [PAGE_BITS-1:0] req_page;
  wire in_seg;
  wire ok;
  wire take;
  wire [2:0] cause;
  wire seg_on;
  wire [PAGE_BITS-1:0] seg_first;
  wire [PAGE_BITS-1:0] seg_last;
  reg [2:0] cause_ff;
  reg [AW-1:0] last_addr_ff;
  reg last_ext_ff;
  reg last_wr_ff;
  // refusal counter width; saturates rather than wraps
  localparam DCNT_W = 16;
  localparam [DCNT_W-1:0] DCNT_MAX = {DCNT_W{1'b1}};
  reg [DCNT_W-1:0] dcnt_ff;
  reg [DCNT_W-1:0] nxt_dcnt;
  // one-hot checker states
  localparam ST_IDLE = 2'b01;
  localparam ST_DONE = 2'b10;
  reg [1:0] st_ff;
  reg [1:0] nxt_st;

  // page number of an address; 512-word pages
  function [PAGE_BITS-1:0] page_of;
    input [AW-1:0] a;
    begin
      page_of = a[`PFWP_PAGE_SHIFT+PAGE_BITS-1:`PFWP_PAGE_SHIFT];
    end
  endfunction

  // lowest page of the contiguous run; zero when the side bit is clear
  function [PAGE_BITS-1:0] seg_lo;
    input [`PFWP_CFG_W-1:0] c;
    begin
      if (c[`PFWP_CFG_END]) begin
        seg_lo = c[`PFWP_CFG_PAGE_HI:`PFWP_CFG_PAGE_LO];
      end else begin
        seg_lo = {PAGE_BITS{1'b0}};
      end
    end
  endfunction

  // highest page of the run; the config page is handled on its own
  function [PAGE_BITS-1:0] seg_hi;
    input [`PFWP_CFG_W-1:0] c;
    begin
      if (c[`PFWP_CFG_END]) begin
        seg_hi = LAST_PAGE[PAGE_BITS-1:0];
      end else begin
        seg_hi = c[`PFWP_CFG_PAGE_HI:`PFWP_CFG_PAGE_LO];
      end
    end
  endfunction

  // segment decision, pure function of config and page
  function seg_hit;
    input [`PFWP_CFG_W-1:0] c;
    input [PAGE_BITS-1:0] p;
    begin
      if (c[`PFWP_CFG_DIS]) begin
        seg_hit = 1'b0;
      end else begin
        // boundary page itself is inside either way
        seg_hit = (p >= seg_lo(c) && p <= seg_hi(c)) ||
          (!c[`PFWP_CFG_CFG] && p == LAST_PAGE);
      end
    end
  endfunction

  // which protections refuse a request; all clear means go ahead
  function [2:0] deny_why;
    input [`PFWP_CFG_W-1:0] c;
    input e;
    input w;
    input s;
    begin
      deny_why = 3'b000;
      if (e) begin
        deny_why[`PFWP_WHY_GCP] = c[`PFWP_CFG_GCP];
      end else if (w) begin
        deny_why[`PFWP_WHY_GLOBAL_WRITE_PROTECT] = !c[`PFWP_CFG_GLOBAL_WRITE_PROTECT];
        deny_why[`PFWP_WHY_SEG] = s;
      end
    end
  endfunction

  pfwp_shadow_chk #(
    .W(`PFWP_CFG_W)
  ) u_shadow (
    .CLOCK(CLOCK),
    .RST(RST),
    .CE(CE),
    .LOAD(ld),
    .LOAD_VAL(HWDATA[`PFWP_CFG_W-1:0]),
    .POKE(poke),
    .POKE_VAL(HWDATA[`PFWP_CFG_W-1:0]),
    .POKE_SH(poke_sh),
    .CFG(cfg),
    .MISMATCH(mismatch)
  );

  // ahb slave: zero wait, always okay
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign bus_wr = a_valid_ff && a_wr_ff && CE;
  assign ld = bus_wr && a_addr_ff == `PFWP_ADDR_LOAD;
  assign poke = bus_wr && (a_addr_ff == `PFWP_ADDR_CFG ||
    a_addr_ff == `PFWP_ADDR_CFGSH);
  assign poke_sh = a_addr_ff == `PFWP_ADDR_CFGSH;

  // address phase capture
  always @(posedge CLOCK) begin
    if (RST) begin
      a_valid_ff <= 1'b0;
      a_wr_ff <= 1'b0;
      a_addr_ff <= 8'h00;
    end else if (CE && HREADY) begin
      a_valid_ff <= HSEL && HTRANS[1];
      a_wr_ff <= HWRITE;
      a_addr_ff <= HADDR[7:0];
    end
  end

  // read data, registered at address phase; unmapped reads zero
  always @(posedge CLOCK) begin
    if (RST) begin
      HRDATA <= 32'h00000000;
    end else if (CE && HREADY && HSEL && HTRANS[1] && !HWRITE) begin
      case (HADDR[7:0])
        `PFWP_ADDR_CFG: HRDATA <= {17'h00000, cfg};
        `PFWP_ADDR_REQ: HRDATA <= {{(32-AW){1'b0}}, sw_addr_ff};
        `PFWP_ADDR_STAT: HRDATA <= {28'h0000000, inseg_ff, PARITY_ERR,
          deny_ff, allow_ff};
        `PFWP_ADDR_CAUSE: HRDATA <= {{(32-DCNT_W-3){1'b0}}, dcnt_ff,
          cause_ff};
        `PFWP_ADDR_LAST: HRDATA <= {{(30-AW){1'b0}}, last_wr_ff,
          last_ext_ff, last_addr_ff};
        `PFWP_ADDR_SEGB: HRDATA <= {{(31-2*PAGE_BITS){1'b0}}, seg_on,
          seg_last, seg_first};
        default: HRDATA <= 32'h00000000;
      endcase
    end
  end

  // software request register; go is a one-cycle pulse
  always @(posedge CLOCK) begin
    if (RST) begin
      sw_addr_ff <= {AW{1'b0}};
      sw_wr_ff <= 1'b0;
      sw_ext_ff <= 1'b0;
      sw_go_ff <= 1'b0;
    end else if (CE) begin
      sw_go_ff <= 1'b0;
      if (bus_wr && a_addr_ff == `PFWP_ADDR_REQ) begin
        sw_addr_ff <= HWDATA[AW-1:0];
        sw_wr_ff <= HWDATA[`PFWP_REQ_WR];
        sw_ext_ff <= HWDATA[`PFWP_REQ_EXT];
        sw_go_ff <= HWDATA[`PFWP_REQ_GO];
      end
    end
  end

  // controller port wins over the software probe
  assign req_go = NVM_REQ || sw_go_ff;
  assign req_addr = NVM_REQ ? NVM_ADDR : sw_addr_ff;
  assign req_wr = NVM_REQ ? NVM_WR : sw_wr_ff;
  assign req_ext = NVM_REQ ? NVM_EXT : sw_ext_ff;
  assign req_page = page_of(req_addr);
  assign in_seg = seg_hit(cfg, req_page);

  // external access: code-protect refuses all; internal ignores it
  // internal write: global write-protect, then segment adds on top
  assign cause = deny_why(cfg, req_ext, req_wr, in_seg);
  assign ok = ~|cause;
  assign take = st_ff == ST_IDLE && req_go;

  // live segment bounds for software; on is low while disabled
  assign seg_on = !cfg[`PFWP_CFG_DIS];
  assign seg_first = seg_lo(cfg);
  assign seg_last = seg_hi(cfg);

  // saturating so a flood of refusals cannot wrap back to zero
  always @* begin
    nxt_dcnt = dcnt_ff;
    if (take && !ok && dcnt_ff != DCNT_MAX) begin
      nxt_dcnt = dcnt_ff + {{(DCNT_W-1){1'b0}}, 1'b1};
    end
  end

  // last request and its refusal causes, kept for software
  always @(posedge CLOCK) begin
    if (RST) begin
      dcnt_ff <= {DCNT_W{1'b0}};
      cause_ff <= 3'b000;
      last_addr_ff <= {AW{1'b0}};
      last_ext_ff <= 1'b0;
      last_wr_ff <= 1'b0;
    end else if (CE) begin
      dcnt_ff <= nxt_dcnt;
      if (take) begin
        cause_ff <= cause;
        last_addr_ff <= req_addr;
        last_ext_ff <= req_ext;
        last_wr_ff <= req_wr;
      end
    end
  end

  // verdict latched before the operation starts
  always @* begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: begin
        if (req_go) begin
          nxt_st = ST_DONE;
        end
      end
      ST_DONE: nxt_st = ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
  end

  always @(posedge CLOCK) begin
    if (RST) begin
      st_ff <= ST_IDLE;
      NVM_DONE <= 1'b0;
      NVM_ALLOW <= 1'b0;
      allow_ff <= 1'b0;
      deny_ff <= 1'b0;
      inseg_ff <= 1'b0;
    end else if (CE) begin
      st_ff <= nxt_st;
      NVM_DONE <= 1'b0;
      if (st_ff == ST_IDLE && req_go) begin
        // denied request still completes, just without the enable
        NVM_DONE <= 1'b1;
        NVM_ALLOW <= ok;
        allow_ff <= ok;
        deny_ff <= !ok;
        inseg_ff <= in_seg;
      end
    end
  end

  // parity error is sticky until reset; reset pulse stretched
  always @* begin
    nxt_rstp = rstp_ff;
    if (mismatch) begin
      nxt_rstp = `PFWP_RSTP_LEN;
    end else if (rstp_ff != 4'h0) begin
      nxt_rstp = rstp_ff - 4'h1;
    end
  end

  always @(posedge CLOCK) begin
    if (RST) begin
      rstp_ff <= 4'h0;
      PARITY_ERR <= 1'b0;
      DEV_RESET <= 1'b0;
    end else if (CE) begin
      rstp_ff <= nxt_rstp;
      if (mismatch) begin
        PARITY_ERR <= 1'b1;
      end
      // high while mismatched and for the full stretch after it
      DEV_RESET <= mismatch || rstp_ff != 4'h0;
    end
  end
endmodule // pfwp_top

// ===== logic/pfwp_map.vh
`ifndef PFWP_MAP_VH
`define PFWP_MAP_VH
// register byte addresses
`define PFWP_ADDR_CFG 8'h00
`define PFWP_ADDR_CFGSH 8'h04
`define PFWP_ADDR_REQ 8'h08
`define PFWP_ADDR_STAT 8'h0C
`define PFWP_ADDR_LOAD 8'h10
`define PFWP_ADDR_CAUSE 8'h14
`define PFWP_ADDR_LAST 8'h18
`define PFWP_ADDR_SEGB 8'h1C
// refusal cause bits
`define PFWP_WHY_GCP 0
`define PFWP_WHY_GLOBAL_WRITE_PROTECT 1
`define PFWP_WHY_SEG 2
// configuration word fields
`define PFWP_CFG_GCP 0
`define PFWP_CFG_GLOBAL_WRITE_PROTECT 1
`define PFWP_CFG_DIS 2
`define PFWP_CFG_END 3
`define PFWP_CFG_CFG 4
`define PFWP_CFG_PAGE_LO 8
`define PFWP_CFG_PAGE_HI 14
`define PFWP_CFG_W 15
// request register fields
`define PFWP_REQ_ADDR_HI 23
`define PFWP_REQ_EXT 24
`define PFWP_REQ_WR 25
`define PFWP_REQ_GO 31
// status bits
`define PFWP_ST_ALLOW 0
`define PFWP_ST_DENY 1
`define PFWP_ST_PERR 2
`define PFWP_ST_INSEG 3
// reset values: all unprogrammed; code-protect on, no other protection
`define PFWP_CFG_RST 15'h7FFF
`define PFWP_PAGE_SHIFT 9
`define PFWP_RSTP_LEN 4'h4
`endif

// ===== logic/pfwp_shadow_chk.v
`timescale 1ns/10ps
// holds config copy and complement shadow, flags any mismatch
module pfwp_shadow_chk #(
  parameter W = 15
) (
  input wire CLOCK,
  input wire RST,
  input wire CE,
  input wire LOAD,
  input wire [W-1:0] LOAD_VAL,
  input wire POKE,
  input wire [W-1:0] POKE_VAL,
  input wire POKE_SH,
  output wire [W-1:0] CFG,
  output wire MISMATCH
);
  reg [W-1:0] cfg_ff;
  reg [W-1:0] shadow_ff;
  // load writes both copies; poke disturbs one side for upset injection
  always @(posedge CLOCK) begin
    if (RST) begin
      cfg_ff <= `PFWP_CFG_RST;
      shadow_ff <= ~`PFWP_CFG_RST;
    end else if (CE) begin
      if (LOAD) begin
        cfg_ff <= LOAD_VAL;
        shadow_ff <= ~LOAD_VAL;
      end else if (POKE && !POKE_SH) begin
        cfg_ff <= POKE_VAL;
      end else if (POKE && POKE_SH) begin
        shadow_ff <= POKE_VAL;
      end
    end
  end
  assign CFG = cfg_ff;
  // continuous compare against the complement
  assign MISMATCH = |(cfg_ff ^ ~shadow_ff);
endmodule // pfwp_shadow_chk

// ===== tb/pfwp_top_asserts.sv
`timescale 1ns/10ps
// verdict handshake and upset response, seen at the top ports only
module pfwp_top_asserts (
  input wire CLOCK,
  input wire RST,
  input wire CE,
  input wire NVM_REQ,
  input wire NVM_WR,
  input wire NVM_EXT,
  input wire NVM_DONE,
  input wire NVM_ALLOW,
  input wire PARITY_ERR,
  input wire DEV_RESET
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  // one verdict per request, held until the next one
  AST_DONE_PULSE: assert property (NVM_DONE && CE |=> !NVM_DONE)
    else $error("done longer than one cycle");
  AST_DONE_AFTER_REQ: assert property (
    CE && $rose(NVM_REQ) && !NVM_DONE |=> NVM_DONE)
    else $error("no done after request");
  AST_ALLOW_STABLE: assert property (!NVM_DONE |-> $stable(NVM_ALLOW))
    else $error("verdict moved without done");
  // internal reads never blocked by any protect bit
  AST_INT_READ_OK: assert property (
    NVM_DONE && $past(NVM_REQ && !NVM_WR && !NVM_EXT) |-> NVM_ALLOW)
    else $error("internal read refused");
  // upset flag sticks and drives the reset request
  AST_PERR_STICKY: assert property (PARITY_ERR |=> PARITY_ERR)
    else $error("parity flag dropped");
  AST_PERR_RESET: assert property ($rose(PARITY_ERR) |-> ##[0:1] DEV_RESET)
    else $error("parity error without reset");
  AST_DRST_HOLD: assert property ($rose(DEV_RESET) |=> DEV_RESET [*4])
    else $error("device reset too short");
  AST_DRST_CAUSE: assert property ($rose(DEV_RESET) |-> ##[0:1] PARITY_ERR)
    else $error("device reset without parity error");
  cover property (NVM_DONE && NVM_ALLOW);
  cover property (NVM_DONE && !NVM_ALLOW);
  cover property ($rose(PARITY_ERR));
endmodule // pfwp_top_asserts

bind pfwp_top pfwp_top_asserts pfwp_top_asserts_inst (.CLOCK(CLOCK),
  .RST(RST), .CE(CE), .NVM_REQ(NVM_REQ), .NVM_WR(NVM_WR),
  .NVM_EXT(NVM_EXT), .NVM_DONE(NVM_DONE), .NVM_ALLOW(NVM_ALLOW),
  .PARITY_ERR(PARITY_ERR), .DEV_RESET(DEV_RESET));

// ===== tb/pfwp_nvm_model.sv
`timescale 1ns/10ps
// flash controller or programmer asking for a verdict
module pfwp_nvm_model (
  input wire CLOCK,
  input wire NVM_DONE,
  input wire NVM_ALLOW,
  output reg NVM_REQ,
  output reg [23:0] NVM_ADDR,
  output reg NVM_WR,
  output reg NVM_EXT
);
  initial begin
    NVM_REQ = 1'b0;
    NVM_ADDR = 24'h0;
    NVM_WR = 1'b0;
    NVM_EXT = 1'b0;
  end
  // gap of 1..4 idle cycles keeps spacing; released lines show inverse
  task check(input [23:0] a, input w, input e, output ok);
    begin
      repeat (1 + a[1:0]) @(posedge CLOCK);
      NVM_REQ <= 1'b1;
      NVM_ADDR <= a;
      NVM_WR <= w;
      NVM_EXT <= e;
      @(posedge CLOCK);
      while (NVM_DONE !== 1'b1) @(posedge CLOCK);
      ok = NVM_ALLOW;
      NVM_REQ <= 1'b0;
      NVM_ADDR <= ~a;
      NVM_WR <= ~w;
      NVM_EXT <= ~e;
    end
  endtask
endmodule // pfwp_nvm_model

// ===== tb/program_flash_write_protect_tb.sv
`timescale 1ns/10ps
`include "pfwp_map.vh"
module program_flash_write_protect_tb;
  reg clock, rst, hsel, hwrite, ok, e_ok, e_seg;
  reg [1:0] htrans;
  reg [31:0] haddr, hwdata, rd, r;
  reg [14:0] cfg;
  reg [23:0] a, addr_n;
  wire hready, hresp, req, wr, ext, done, allow, perr, drst;
  wire [23:0] addr;
  wire [31:0] hrdata;
  integer n_fail, tests_run, seed, i, k;

  pfwp_top pfwp_top_inst (.CLOCK(clock), .RST(rst), .CE(1'b1),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready),
    .HRESP(hresp), .HRDATA(hrdata), .NVM_REQ(req), .NVM_ADDR(addr),
    .NVM_WR(wr), .NVM_EXT(ext), .NVM_DONE(done), .NVM_ALLOW(allow),
    .PARITY_ERR(perr), .DEV_RESET(drst));
  pfwp_nvm_model pfwp_nvm_model_inst (.CLOCK(clock), .NVM_DONE(done),
    .NVM_ALLOW(allow), .NVM_REQ(req), .NVM_ADDR(addr), .NVM_WR(wr),
    .NVM_EXT(ext));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // verdict for one request; last page fixed at the default top page
  function exp_seg(input [14:0] c, input [23:0] ad);
    begin
      exp_seg = !c[2] && (c[3] ? ad[15:9] >= c[14:8] :
        ad[15:9] <= c[14:8] || !c[4] && ad[15:9] == 7'h7F);
    end
  endfunction
  function exp_allow(input [14:0] c, input [23:0] ad, input w, input e);
    begin
      exp_allow = e ? !c[0] : !w || c[1] && !exp_seg(c, ad);
    end
  endfunction
  function [2:0] exp_why(input [14:0] c, input [23:0] ad, input w,
    input e);
    begin
      exp_why = e ? {2'b00, c[0]} : w ? {exp_seg(c, ad), !c[1], 1'b0} :
        3'b000;
    end
  endfunction
  task chk(input [31:0] e, input [31:0] g, input [63:0] nm);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        $display("wrong value %0s exp %h got %h", nm, e, g);
        n_fail = n_fail + 1;
      end
    end
  endtask
  // single word transfer; waits on hready, data taken at second edge
  task ahb(input w, input [31:0] ad, input [31:0] wd, output [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= ad;
      hwrite <= w;
      @(posedge clock);
      while (hready !== 1'b1) @(posedge clock);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clock);
      while (hready !== 1'b1) @(posedge clock);
      d = hrdata;
    end
  endtask
  task do_reset;
    begin
      rst <= 1'b1;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  // main sequence: map, every protect mode, then an upset
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    n_fail = 0;
    tests_run = 0;
    seed = 32'hBC2F;
    do_reset;
    ahb(1'b0, `PFWP_ADDR_CFG, 32'h0, rd);
    chk(32'h7FFF, rd, "cfg");
    chk(32'h0, {31'h0, hresp}, "hresp");
    ahb(1'b0, 32'h20, 32'h0, rd);
    chk(32'h0, rd, "unmap");
    for (i = 0; i < 32; i = i + 1) begin
      cfg = $random(seed);
      cfg[4:0] = i[4:0];
      ahb(1'b1, `PFWP_ADDR_LOAD, {17'h0, cfg}, rd);
      // pages just below, on and above the boundary, and the top page
      for (k = 0; k < 6; k = k + 1) begin
        a = $random(seed);
        r = $random(seed);
        a[8:0] = {9{r[3]}};
        if (k < 4)
          a[15:9] = k == 3 ? 7'h7F : cfg[14:8] + k[6:0] - 7'h1;
        e_ok = exp_allow(cfg, a, r[0], r[1] & r[2]);
        e_seg = exp_seg(cfg, a);
        // last probe goes through the software request register
        if (k < 5) begin
          pfwp_nvm_model_inst.check(a, r[0], r[1] & r[2], ok);
        end else begin
          ahb(1'b1, `PFWP_ADDR_REQ, {1'b1, 5'h00, r[0], r[1] & r[2], a},
            rd);
          @(posedge clock);
        end
        ahb(1'b0, `PFWP_ADDR_STAT, 32'h0, rd);
        if (k == 5) begin
          ok = rd[0];
        end
        chk({31'h0, e_ok}, {31'h0, ok},
          "allow");
        chk({28'h0, e_seg, 1'b0, !e_ok, e_ok}, rd, "stat");
        ahb(1'b0, `PFWP_ADDR_CAUSE, 32'h0, rd);
        chk({29'h0, exp_why(cfg, a, r[0], r[1] & r[2])}, {29'h0, rd[2:0]},
          "cause");
      end
    end
    // value upset so the shadow is no longer its complement
    ahb(1'b1, `PFWP_ADDR_CFG, {17'h0, ~cfg}, rd);
    repeat (3) @(posedge clock);
    chk(32'h3, {30'h0, perr, drst}, "upset");
    ahb(1'b1, `PFWP_ADDR_LOAD, {17'h0, cfg}, rd);
    repeat (12) @(posedge clock);
    chk(32'h2, {30'h0, perr, drst}, "sticky");
    do_reset;
    chk(32'h0, {30'h0, perr, drst}, "cleared");
    print_verdict;
  end
  // run needs about 1700 cycles; cut a hang short
  initial begin
    #3000000;
    n_fail = n_fail + 1;
    print_verdict;
  end
endmodule // program_flash_write_protect_tb
